/* File: core/cipher_pkg.sv */
`default_nettype none
package cipher_pkg;
	// Register bus and block types.
	typedef logic [7:0] addr_t;
	typedef logic [7:0] byte_t;
	typedef logic [127:0] block_t;

	// Register byte addresses.
	localparam addr_t ADDR_INPUT_PORT  = 8'hb1;
	localparam addr_t ADDR_OUTPUT_PORT = 8'hb2;
	localparam addr_t ADDR_CTRL_STATUS = 8'hb3;
	localparam addr_t ADDR_IRQ         = 8'hb0;

	// Field positions of the control/status register.
	localparam int CS_START_POS = 0;
	localparam int CS_CMD_LSB   = 1;
	localparam int CS_READY_POS = 3;
	localparam int CS_MODE_LSB  = 4;
	// Field positions of the interrupt register.
	localparam int IRQ_FLAG_POS   = 0;
	localparam int IRQ_ENABLE_POS = 1;

	// Command codes.
	localparam logic [1:0] CMD_ENCRYPT  = 2'h0;
	localparam logic [1:0] CMD_DECRYPT  = 2'h1;
	localparam logic [1:0] CMD_LOAD_KEY = 2'h2;
	localparam logic [1:0] CMD_LOAD_IV  = 2'h3;

	// Chaining mode codes; 3'h6 and 3'h7 are reserved.
	localparam logic [2:0] MODE_CBC     = 3'h0;
	localparam logic [2:0] MODE_CFB     = 3'h1;
	localparam logic [2:0] MODE_OFB     = 3'h2;
	localparam logic [2:0] MODE_CTR     = 3'h3;
	localparam logic [2:0] MODE_ECB     = 3'h4;
	localparam logic [2:0] MODE_CBC_MAC = 3'h5;

	// Values after reset.
	localparam logic [2:0] RST_MODE  = 3'h0;
	localparam logic [1:0] RST_CMD   = 2'h0;
	localparam logic       RST_READY = 1'b1;
	localparam byte_t      RST_BYTE  = 8'h00;

	// Transfer sizes and core latency in clock cycles.
	localparam logic [3:0] LAST_BLOCK_BYTE = 4'hf;
	localparam logic [3:0] LAST_PART_BYTE  = 4'h3;
	localparam logic [1:0] LAST_PART       = 2'h3;
	localparam int         CORE_CYCLES     = 12;
endpackage
`default_nettype wire

/* File: core/cipher_reset_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cipher_reset_sync (
	input  wire logic clk_i,   // System clock.
	input  wire logic rstn_i,  // Asynchronous reset, active low.
	output var  logic rstn_o   // Released reset, active low.
);
	logic meta_n;

	// Release is delayed two edges so that no flop sees a runt reset edge.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_n <= 1'b0;
			rstn_o <= 1'b0;
		end else begin
			meta_n <= 1'b1;
			rstn_o <= meta_n;
		end
	end
endmodule
`default_nettype wire

/* File: core/cipher_core_stub.sv */
`timescale 1ns/1ps
`default_nettype none
module cipher_core_stub #(
	parameter int LATENCY = cipher_pkg::CORE_CYCLES  // Cycles from start to done.
) (
	input  wire logic              clk_i,      // System clock.
	input  wire logic              rst_n_i,    // Synchronised reset, active low.
	input  wire logic              clear_i,    // Deep power mode clear.
	input  wire logic              start_i,    // One-cycle start pulse.
	input  wire logic              decrypt_i,  // Inverse transform when high.
	input  wire cipher_pkg::block_t key_i,     // Block key.
	input  wire cipher_pkg::block_t data_i,    // Operand.
	output var  logic              done_o,     // One-cycle done pulse.
	output var  cipher_pkg::block_t result_o   // Result, valid with done.
);
	import cipher_pkg::*;

	logic [7:0] count;
	logic       busy;

	// Stand-in for the round datapath: an invertible keyed mix with a fixed latency.
	function automatic block_t mix(input block_t d, input block_t k, input logic inv);
		block_t t;
		t = '0;
		if (inv)
			t = {d[7:0], d[127:8]} ^ k;
		else begin
			t = d ^ k;
			t = {t[119:0], t[127:120]};
		end
		return t;
	endfunction

	// Latency counter; a new start restarts it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count    <= 8'h00;
			busy     <= 1'b0;
			done_o   <= 1'b0;
			result_o <= '0;
		end else if (clear_i) begin
			count    <= 8'h00;
			busy     <= 1'b0;
			done_o   <= 1'b0;
			result_o <= '0;
		end else if (start_i) begin
			count    <= 8'(LATENCY - 1);
			busy     <= 1'b1;
			done_o   <= 1'b0;
			result_o <= mix(data_i, key_i, decrypt_i);
		end else begin
			done_o <= busy && (count == 8'h00);
			if (count != 8'h00)
				count <= count - 8'h01;
			else
				busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: core/cipher_coproc.sv */
// Operation
// RULE1 - Host zero-pads a short final block.
// RULE2 - Control by CPU, data ports preferably DMA.
// RULE3 - Host sets up two DMA channels first.
// RULE4 - Start command raises a DMA trigger.
// RULE5 - Host restarts each block on interrupt.
// RULE6 - CFB, OFB, CTR work in 32-bit parts.
// RULE7 - Triggers pace each 32-bit part.
// RULE8 - MAC: CBC-MAC blocks, last block CBC.
// RULE9 - Host compares read-back MAC to expected.
// RULE10 - Host builds zero IV and first block.
// RULE11 - Host fills authentication flag byte fields.
// RULE12 - Host truncates tag to its length.
// RULE13 - Counter zero for tag, nonzero for data.
// RULE14 - Mode and IV load written together.
// RULE15 - Encryption reloads IV with nonzero counter.
// RULE16 - Decryption CTR follows tag step directly.
// RULE17 - Counter increments automatically over 32 bits.
// RULE18 - Host splits and pads tag and ciphertext.
// RULE19 - Interrupt when a block completes.
// RULE20 - Download request when input is needed.
// RULE21 - Upload request when output is waiting.
// RULE22 - Deep power modes restore reset values.
// RULE23 - Command field selects operation run on start.
// RULE24 - Mode field encodes chaining mode.
// RULE25 - Start bit launches, hardware clears it.
// RULE26 - Ready low while busy, resets high.
// RULE27 - Interrupt flag sticky until software clears.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cipher_coproc #(
	parameter int CORE_LATENCY = cipher_pkg::CORE_CYCLES  // Core cycles per transform.
) (
	input  wire logic              CLK_SYS_I,                  // System clock, 20 MHz.
	input  wire logic              RSTN_I,                     // Reset, active low.
	input  wire cipher_pkg::addr_t ADDR_I,                     // Register address.
	input  wire cipher_pkg::byte_t WDATA_I,                    // Write data.
	input  wire logic              WR_I,                       // Write strobe.
	input  wire logic              RD_I,                       // Read strobe.
	output var  cipher_pkg::byte_t RDATA_O,                    // Read data, next cycle.
	input  wire logic              DEEP_POWER_MODE_A_I,        // Deep power mode entry.
	input  wire logic              DEEP_POWER_MODE_B_I,        // Deepest power mode entry.
	output var  logic              CIPHER_DOWNLOAD_REQUEST_O,  // Input DMA trigger.
	output var  logic              CIPHER_UPLOAD_REQUEST_O,    // Output DMA trigger.
	output var  logic              CIPHER_DONE_INTERRUPT_O     // Block done interrupt.
);
	import cipher_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_LOAD, S_CORE, S_UNLOAD, S_KSTREAM, S_PART_IN, S_PART_OUT
	} seq_e;

	logic       rst_n;
	logic       pm_clear;
	logic [2:0] mode;
	logic [1:0] cmd;
	logic       start_bit;
	logic       ready;
	logic       irq_flag;
	logic       irq_enable;
	byte_t      last_input;
	seq_e       state;
	logic [1:0] run_cmd;
	logic [2:0] run_mode;
	logic [3:0] byte_cnt;
	logic [1:0] part;
	block_t     key;
	block_t     chain;
	block_t     ctr_blk;
	block_t     kstream;
	block_t     in_blk;
	block_t     out_blk;
	logic       core_start;
	logic       core_decrypt;
	block_t     core_operand;
	logic       core_done;
	block_t     core_result;
	logic       block_done;
	logic       wr_ctrl;
	logic       wr_input;
	logic       wr_irq;
	logic       rd_output;
	logic       is_decrypt;
	logic [31:0] in_word;
	logic [31:0] out_word;

	// Part modes cut each block into four words; reserved codes act as ECB.
	function automatic logic part_mode(input logic [2:0] m);
		return (m == MODE_CFB) || (m == MODE_OFB) || (m == MODE_CTR);
	endfunction

	// Word of a block chosen by part index, leftmost word first.
	function automatic logic [31:0] word_of(input block_t b, input logic [1:0] p);
		return b[127 - 32 * p -: 32];
	endfunction

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!rst_n);

	cipher_reset_sync u_reset_sync (
		.clk_i  (CLK_SYS_I),
		.rstn_i (RSTN_I),
		.rstn_o (rst_n)
	);

	cipher_core_stub #(
		.LATENCY (CORE_LATENCY)
	) u_core (
		.clk_i     (CLK_SYS_I),
		.rst_n_i   (rst_n),
		.clear_i   (pm_clear),
		.start_i   (core_start),
		.decrypt_i (core_decrypt),
		.key_i     (key),
		.data_i    (core_operand),
		.done_o    (core_done),
		.result_o  (core_result)
	);

	// Address decode; the power controller is on this clock, so no synchroniser.
	assign pm_clear   = DEEP_POWER_MODE_A_I | DEEP_POWER_MODE_B_I;  // [RULE22]
	assign wr_ctrl    = WR_I && (ADDR_I == ADDR_CTRL_STATUS);  // [RULE2]
	assign wr_input   = WR_I && (ADDR_I == ADDR_INPUT_PORT);
	assign wr_irq     = WR_I && (ADDR_I == ADDR_IRQ);
	assign rd_output  = RD_I && (ADDR_I == ADDR_OUTPUT_PORT);
	assign is_decrypt = (run_cmd == CMD_DECRYPT);
	assign in_word    = {in_blk[23:0], WDATA_I};
	assign out_word   = in_word ^ word_of(kstream, part);
	assign block_done = (state == S_UNLOAD && rd_output && byte_cnt == LAST_BLOCK_BYTE)
		|| (state == S_CORE && core_done && run_mode == MODE_CBC_MAC
			&& !part_mode(run_mode))
		|| (state == S_PART_OUT && rd_output && byte_cnt == LAST_PART_BYTE
			&& part == LAST_PART);

	// Core operand: CBC encryption folds the chain in, part modes encrypt the chain, CTR the counter block.
	always_comb begin
		core_decrypt = 1'b0;
		core_operand = {in_blk[119:0], WDATA_I};
		if ((start_bit && part_mode(mode)) || state == S_IDLE || state == S_KSTREAM) begin
			core_operand = (mode == MODE_CTR) ? ctr_blk : chain;  // [RULE16]
		end else if (!is_decrypt && (run_mode == MODE_CBC || run_mode == MODE_CBC_MAC)) begin
			core_operand = {in_blk[119:0], WDATA_I} ^ chain;
		end else if (is_decrypt && run_mode != MODE_ECB && run_mode != 3'h6 && run_mode != 3'h7) begin
			core_decrypt = 1'b1;
		end else begin
			core_decrypt = is_decrypt;
		end
		core_start = 1'b0;
		if (start_bit && !pm_clear && part_mode(mode)
				&& (cmd == CMD_ENCRYPT || cmd == CMD_DECRYPT))
			core_start = 1'b1;  // [RULE6]
		else if (state == S_LOAD && wr_input && byte_cnt == LAST_BLOCK_BYTE
				&& (run_cmd == CMD_ENCRYPT || run_cmd == CMD_DECRYPT))
			core_start = 1'b1;
	end

	// Control fields; the start bit is taken on a one and cleared the next cycle.
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			mode      <= RST_MODE;
			cmd       <= RST_CMD;
			start_bit <= 1'b0;
		end else if (pm_clear) begin
			mode      <= RST_MODE;  // [RULE22]
			cmd       <= RST_CMD;
			start_bit <= 1'b0;
		end else if (wr_ctrl) begin
			mode      <= WDATA_I[CS_MODE_LSB +: 3];  // [RULE24]
			cmd       <= WDATA_I[CS_CMD_LSB +: 2];  // [RULE23]
			start_bit <= WDATA_I[CS_START_POS];  // [RULE25]
		end else begin
			start_bit <= 1'b0;  // [RULE25]
		end
	end

	// Interrupt flag and enable; a completing block wins over a clear in the same cycle.
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag                <= 1'b0;
			irq_enable              <= 1'b0;
			CIPHER_DONE_INTERRUPT_O <= 1'b0;
		end else if (pm_clear) begin
			irq_flag                <= 1'b0;
			irq_enable              <= 1'b0;
			CIPHER_DONE_INTERRUPT_O <= 1'b0;
		end else begin
			if (block_done)
				irq_flag <= 1'b1;  // [RULE19]
			else if (wr_irq && WDATA_I[IRQ_FLAG_POS])
				irq_flag <= 1'b0;  // [RULE27]
			if (wr_irq)
				irq_enable <= WDATA_I[IRQ_ENABLE_POS];
			CIPHER_DONE_INTERRUPT_O <= (irq_flag || block_done) && irq_enable;
		end
	end

	// Sequencer: launches a command, collects bytes, runs the core, hands results out.
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			state    <= S_IDLE;
			ready    <= RST_READY;
			run_cmd  <= RST_CMD;
			run_mode <= RST_MODE;
			byte_cnt <= 4'h0;
			part     <= 2'h0;
			key      <= '0;
			chain    <= '0;
			ctr_blk  <= '0;
			kstream  <= '0;
			in_blk   <= '0;
			out_blk  <= '0;
		end else if (pm_clear) begin
			state    <= S_IDLE;  // [RULE22]
			ready    <= RST_READY;
			run_cmd  <= RST_CMD;
			run_mode <= RST_MODE;
			byte_cnt <= 4'h0;
			part     <= 2'h0;
			key      <= '0;
			chain    <= '0;
			ctr_blk  <= '0;
			kstream  <= '0;
			in_blk   <= '0;
			out_blk  <= '0;
		end else if (start_bit) begin
			// Any start, a key or IV load included, aborts whatever was running.
			run_cmd  <= cmd;  // [RULE23]
			run_mode <= mode;
			byte_cnt <= 4'h0;
			part     <= 2'h0;
			ready    <= 1'b0;  // [RULE26]
			if (part_mode(mode) && (cmd == CMD_ENCRYPT || cmd == CMD_DECRYPT))
				state <= S_KSTREAM;
			else
				state <= S_LOAD;
		end else begin
			case (state)
				S_LOAD: begin
					if (wr_input) begin
						in_blk   <= {in_blk[119:0], WDATA_I};
						byte_cnt <= byte_cnt + 4'h1;
						if (byte_cnt == LAST_BLOCK_BYTE) begin
							case (run_cmd)
								CMD_LOAD_KEY: begin
									key   <= {in_blk[119:0], WDATA_I};
									ready <= 1'b1;
									state <= S_IDLE;
								end
								CMD_LOAD_IV: begin
									chain   <= {in_blk[119:0], WDATA_I};
									ctr_blk <= {in_blk[119:0], WDATA_I};
									ready   <= 1'b1;
									state   <= S_IDLE;
								end
								default: state <= S_CORE;
							endcase
						end
					end
				end
				S_CORE: begin
					if (core_done) begin
						byte_cnt <= 4'h0;
						if (run_mode == MODE_CBC || run_mode == MODE_CBC_MAC) begin
							chain   <= is_decrypt ? in_blk : core_result;
							out_blk <= is_decrypt ? core_result ^ chain : core_result;
						end else begin
							out_blk <= core_result;
						end
						// The MAC pass keeps its result in out_blk, and in the chain when encrypting, with no upload.
						if (run_mode == MODE_CBC_MAC) begin
							ready <= 1'b1;  // [RULE8]
							state <= S_IDLE;
						end else begin
							state <= S_UNLOAD;  // [RULE21]
						end
					end
				end
				S_UNLOAD: begin
					if (rd_output) begin
						out_blk  <= {out_blk[119:0], 8'h00};
						byte_cnt <= byte_cnt + 4'h1;
						if (byte_cnt == LAST_BLOCK_BYTE) begin
							ready <= 1'b1;  // [RULE26]
							state <= S_IDLE;
						end
					end
				end
				S_KSTREAM: begin
					if (core_done) begin
						kstream <= core_result;
						state   <= S_PART_IN;  // [RULE20]
					end
				end
				S_PART_IN: begin
					if (wr_input) begin
						in_blk   <= {in_blk[119:0], WDATA_I};
						byte_cnt <= byte_cnt + 4'h1;
						if (byte_cnt == LAST_PART_BYTE) begin
							// The feedback word is always the ciphertext side.
							if (run_mode == MODE_CFB)
								chain[127 - 32 * part -: 32] <= is_decrypt ? in_word : out_word;
							out_blk  <= {out_word, 96'h0};
							byte_cnt <= 4'h0;
							state    <= S_PART_OUT;  // [RULE6]
						end
					end
				end
				S_PART_OUT: begin
					if (rd_output) begin
						out_blk  <= {out_blk[119:0], 8'h00};
						byte_cnt <= byte_cnt + 4'h1;
						if (byte_cnt == LAST_PART_BYTE) begin
							byte_cnt <= 4'h0;
							if (part == LAST_PART) begin
								if (run_mode == MODE_OFB)
									chain <= kstream;
								// Only the low word counts, so it wraps after 2^32 blocks.
								ctr_blk <= {ctr_blk[127:32], ctr_blk[31:0] + 32'h1};  // [RULE17]
								ready   <= 1'b1;
								state   <= S_IDLE;
							end else begin
								part  <= part + 2'h1;
								state <= S_PART_IN;  // [RULE7]
							end
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// DMA triggers pulse once for each block or word that must move.
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			CIPHER_DOWNLOAD_REQUEST_O <= 1'b0;
			CIPHER_UPLOAD_REQUEST_O   <= 1'b0;
		end else if (pm_clear) begin
			CIPHER_DOWNLOAD_REQUEST_O <= 1'b0;
			CIPHER_UPLOAD_REQUEST_O   <= 1'b0;
		end else begin
			CIPHER_DOWNLOAD_REQUEST_O <= (start_bit && !(part_mode(mode)
				&& (cmd == CMD_ENCRYPT || cmd == CMD_DECRYPT)))  // [RULE4]
				|| (!start_bit && state == S_KSTREAM && core_done)  // [RULE20]
				|| (!start_bit && state == S_PART_OUT && rd_output
					&& byte_cnt == LAST_PART_BYTE && part != LAST_PART);  // [RULE7]
			CIPHER_UPLOAD_REQUEST_O <= !start_bit && ((state == S_CORE && core_done
				&& run_mode != MODE_CBC_MAC)
				|| (state == S_PART_IN && wr_input && byte_cnt == LAST_PART_BYTE));  // [RULE21]
		end
	end

	// Read data and the input port echo; unmapped addresses read zero.
	always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
		if (!rst_n) begin
			RDATA_O    <= RST_BYTE;
			last_input <= RST_BYTE;
		end else if (pm_clear) begin
			RDATA_O    <= RST_BYTE;
			last_input <= RST_BYTE;
		end else begin
			if (wr_input)
				last_input <= WDATA_I;
			RDATA_O <= RST_BYTE;
			if (RD_I) begin
				case (ADDR_I)
					ADDR_CTRL_STATUS: RDATA_O <= {1'b0, mode, ready, cmd, start_bit};
					ADDR_INPUT_PORT:  RDATA_O <= last_input;
					ADDR_OUTPUT_PORT: RDATA_O <= out_blk[127:120];
					ADDR_IRQ:         RDATA_O <= {6'h00, irq_enable, irq_flag};
					default:          RDATA_O <= RST_BYTE;
				endcase
			end
		end
	end

	sequence s_word_loaded;
		state == S_PART_IN && wr_input && byte_cnt == LAST_PART_BYTE && !start_bit && !pm_clear;
	endsequence
	sequence s_word_offered;
		state == S_PART_OUT && CIPHER_UPLOAD_REQUEST_O;
	endsequence

	property p_start_clears;
		start_bit && !wr_ctrl |=> !start_bit;
	endproperty
	a_start_clears: assert property (p_start_clears) else $error("start bit not cleared"); // [RULE25]

	property p_start_trigger;
		start_bit && !pm_clear |=> CIPHER_DOWNLOAD_REQUEST_O || state == S_KSTREAM;
	endproperty
	a_start_trigger: assert property (p_start_trigger) else $error("start gave no trigger"); // [RULE4]

	property p_ready_busy;
		state != S_IDLE |-> !ready;
	endproperty
	a_ready_busy: assert property (p_ready_busy) else $error("ready high while busy"); // [RULE26]

	property p_flag_sticky;
		irq_flag && !(wr_irq && WDATA_I[IRQ_FLAG_POS]) && !pm_clear |=> irq_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // [RULE27]

	property p_done_flag;
		block_done && !pm_clear |=> irq_flag && ready && state == S_IDLE;
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("block done not flagged"); // [RULE19]

	property p_word_upload;
		s_word_loaded |=> s_word_offered;
	endproperty
	a_word_upload: assert property (p_word_upload) else $error("word result not offered"); // [RULE6]

	property p_part_download;
		state == S_PART_IN && $past(state) == S_PART_OUT |-> CIPHER_DOWNLOAD_REQUEST_O;
	endproperty
	a_part_download: assert property (p_part_download) else $error("no part trigger"); // [RULE20]

	property p_ctr_step;
		block_done && part_mode(run_mode) && !pm_clear
			|=> ctr_blk[31:0] == $past(ctr_blk[31:0]) + 32'h1;
	endproperty
	a_ctr_step: assert property (p_ctr_step) else $error("counter not stepped"); // [RULE17]

	property p_power_clear;
		pm_clear |=> ready && mode == RST_MODE && !irq_flag && key == '0 && state == S_IDLE;
	endproperty
	a_power_clear: assert property (p_power_clear) else $error("deep power did not clear"); // [RULE22]
endmodule
`default_nettype wire

/* File: sim/cipher_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cipher_host_model (
	input  wire logic              clk_i,     // System clock.
	input  wire logic              dl_req_i,  // Download trigger from the device.
	input  wire logic              ul_req_i,  // Upload trigger from the device.
	input  wire cipher_pkg::byte_t rdata_i,   // Read data.
	output var  cipher_pkg::addr_t addr_o,    // Register address.
	output var  cipher_pkg::byte_t wdata_o,   // Write data.
	output var  logic              wr_o,      // Write strobe.
	output var  logic              rd_o       // Read strobe.
);
	import cipher_pkg::*;
	int dl_count = 0;
	int ul_count = 0;

	// Bus idles with no strobe from time zero.
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// Triggers are one-cycle pulses, so they are counted for later waits.
	always_ff @(posedge clk_i) begin
		if (dl_req_i) dl_count <= dl_count + 1;
		if (ul_req_i) ul_count <= ul_count + 1;
	end

	// Released lines show inverted values so nothing stale looks valid.
	task automatic reg_write(input addr_t a, input byte_t d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask

	// Read data stand only in the cycle after the strobe, so sample mid-cycle.
	task automatic reg_read(input addr_t a, output byte_t d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clk_i);
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

/* File: sim/cipher_coproc_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cipher_coproc_bench;
	import cipher_pkg::*;
	logic  clk;
	logic  rstn;
	logic  wr;
	logic  rd;
	logic  pm_a;
	logic  pm_b;
	logic  dl_req;
	logic  ul_req;
	logic  irq;
	addr_t addr;
	byte_t wdata;
	byte_t rdata;
	byte_t got;
	int    fail_count = 0;
	int    comparisons = 0;
	int    exp_dl = 0;
	int    exp_ul = 0;
	// First block flag byte: no additional data, a 16-byte tag and a six-byte length field.
	localparam byte_t AUTH_FLAG = {1'b0, 1'b0, 3'((16 - 2) / 2), 3'(6 - 1)};

	// System clock at 20 MHz.
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// A short core latency keeps the run brief.
	cipher_coproc #(.CORE_LATENCY(2)) uut (
		.CLK_SYS_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .DEEP_POWER_MODE_A_I(pm_a),
		.DEEP_POWER_MODE_B_I(pm_b), .CIPHER_DOWNLOAD_REQUEST_O(dl_req),
		.CIPHER_UPLOAD_REQUEST_O(ul_req), .CIPHER_DONE_INTERRUPT_O(irq));

	cipher_host_model host (.clk_i(clk), .dl_req_i(dl_req), .ul_req_i(ul_req),
		.rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	// Result checks and the single closing point.
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check_byte(input byte_t g, input byte_t e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH at %0t: byte %h expected %h", $time, g, e);
		end
	endtask

	task automatic check_bit(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH at %0t: bit %b expected %b", $time, g, e);
		end
	endtask

	function automatic byte_t ctl(input logic [2:0] m, input logic [1:0] c, input logic s);
		return {1'b0, m, 1'b0, c, s};
	endfunction

	// Waits for the next trigger pulse; a hang ends the run.
	task automatic wait_req(input logic up);
		int n;
		n = 0;
		if (up) exp_ul++;
		else exp_dl++;
		while ((up ? host.ul_count < exp_ul : host.dl_count < exp_dl) && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			fail_count++;
			$display("MISMATCH at %0t: trigger timeout", $time);
			print_verdict();
		end
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		got = 8'h00;
		while (got[3] !== 1'b1 && n < 100) begin
			host.reg_read(ADDR_CTRL_STATUS, got);
			n++;
		end
		check_bit(got[3], 1'b1);
		if (got[3] !== 1'b1) print_verdict();
	endtask

	// One command: key and IV loads have no upload, part modes repeat per word.
	task automatic run_block(input byte_t cs, input byte_t din, input int n, input int parts,
			input logic out, input byte_t exp);
		host.reg_write(ADDR_CTRL_STATUS, cs);
		for (int p = 0; p < parts; p++) begin
			wait_req(1'b0);
			if (out && p == 0) begin
				host.reg_read(ADDR_CTRL_STATUS, got);
				check_bit(got[3], 1'b0);
				check_bit(got[0], 1'b0);
			end
			repeat (n) host.reg_write(ADDR_INPUT_PORT, din);
			if (out) begin
				wait_req(1'b1);
				repeat (n) begin
					host.reg_read(ADDR_OUTPUT_PORT, got);
					check_byte(got, exp);
				end
			end
		end
		wait_ready();
	endtask

	// Zero key and uniform bytes make every result equal its input.
	task automatic block_irq(input byte_t cs, input byte_t din);
		run_block(cs, din, 16, 1, 1'b1, din);
		host.reg_read(ADDR_IRQ, got);
		check_byte(got, 8'h03);
		check_bit(irq, 1'b1);
		host.reg_read(ADDR_IRQ, got);
		check_byte(got, 8'h03);
		host.reg_write(ADDR_IRQ, 8'h03);
		host.reg_read(ADDR_IRQ, got);
		check_byte(got, 8'h02);
		check_bit(irq, 1'b0);
	endtask

	// Main sequence.
	initial begin
		rstn = 1'b0;
		pm_a = 1'b0;
		pm_b = 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		host.reg_read(ADDR_CTRL_STATUS, got);
		check_byte(got, 8'h08);
		host.reg_read(ADDR_IRQ, got);
		check_byte(got, 8'h00);
		host.reg_read(8'h7e, got);
		check_byte(got, 8'h00);
		for (int m = 0; m < 8; m++) begin
			for (int c = 0; c < 4; c++) begin
				host.reg_write(ADDR_CTRL_STATUS, ctl(3'(m), 2'(c), 1'b0));
				host.reg_read(ADDR_CTRL_STATUS, got);
				check_byte(got, ctl(3'(m), 2'(c), 1'b0) | 8'h08);
			end
		end
		host.reg_write(ADDR_IRQ, 8'h02);
		run_block(ctl(MODE_CBC, CMD_LOAD_KEY, 1'b1), 8'h00, 16, 1, 1'b0, 8'h00);
		host.reg_read(ADDR_IRQ, got);
		check_byte(got, 8'h02);
		block_irq(ctl(MODE_ECB, CMD_ENCRYPT, 1'b1), 8'h5a);
		block_irq(ctl(MODE_ECB, CMD_DECRYPT, 1'b1), 8'ha5);
		run_block(ctl(MODE_CFB, CMD_LOAD_IV, 1'b1), 8'h00, 16, 1, 1'b0, 8'h00);
		run_block(ctl(MODE_CFB, CMD_ENCRYPT, 1'b1), 8'h3c, 4, 4, 1'b1, 8'h3c);
		check_byte(8'(host.dl_count), 8'(exp_dl));
		check_byte(8'(host.ul_count), 8'(exp_ul));
		for (int p = 0; p < 2; p++) begin
			host.reg_write(ADDR_IRQ, 8'h02);
			host.reg_write(ADDR_CTRL_STATUS, ctl(MODE_CTR, CMD_DECRYPT, 1'b0));
			@(posedge clk);
			pm_a <= (p == 0);
			pm_b <= (p == 1);
			@(posedge clk);
			pm_a <= 1'b0;
			pm_b <= 1'b0;
			host.reg_read(ADDR_IRQ, got);
			check_byte(got, 8'h00);
			host.reg_read(ADDR_CTRL_STATUS, got);
			check_byte(got, 8'h08);
		end
		// Authenticated sequence; the cleared key and uniform bytes keep each result exact.
		run_block(ctl(MODE_CBC, CMD_LOAD_IV, 1'b1), 8'h00, 16, 1, 1'b0, 8'h00);
		run_block(ctl(MODE_CBC_MAC, CMD_ENCRYPT, 1'b1), AUTH_FLAG, 16, 1, 1'b0, 8'h00);
		run_block(ctl(MODE_CBC, CMD_ENCRYPT, 1'b1), 8'h00, 16, 1, 1'b1, AUTH_FLAG);
		run_block(ctl(MODE_OFB, CMD_LOAD_IV, 1'b1), 8'h00, 16, 1, 1'b0, 8'h00);
		run_block(ctl(MODE_OFB, CMD_ENCRYPT, 1'b1), AUTH_FLAG, 4, 4, 1'b1,
			AUTH_FLAG);
		run_block(ctl(MODE_CTR, CMD_LOAD_IV, 1'b1), 8'h01, 16, 1, 1'b0, 8'h00);
		run_block(ctl(MODE_CTR, CMD_ENCRYPT, 1'b1), 8'h00, 4, 4, 1'b1, 8'h01);
		print_verdict();
	end
endmodule
`default_nettype wire
